//--- logic/plb_pkg.sv
// shared constants of the programmable logic block: sizes, term indices,
// register offsets, field positions and reset values.
// assumes a 32-bit apb slave decoding a 12-bit byte address.
package plb_pkg;

    // array sizes
    localparam int PLB_N_IN = 36;
    localparam int PLB_N_LIT = 72;
    localparam int PLB_N_PT = 87;
    localparam int PLB_N_GEN = 80;
    localparam int PLB_N_MC = 16;
    localparam int PLB_N_OE = 4;
    localparam int PLB_HALF = 8;
    localparam int PLB_SEL_W = 8;

    // special product term indices
    localparam int PLB_PT_OE0 = 80;
    localparam int PLB_PT_SET = 84;
    localparam int PLB_PT_RST = 85;
    localparam int PLB_PT_CLK = 86;

    // register byte offsets
    localparam logic [11:0] PLB_ADDR_POL = 12'h000;
    localparam logic [11:0] PLB_ADDR_MCOUT = 12'h004;
    localparam logic [11:0] PLB_ADDR_IOOE = 12'h008;
    localparam logic [11:0] PLB_ADDR_ROUTE = 12'h100;
    localparam logic [11:0] PLB_ADDR_MCCFG = 12'h200;
    localparam logic [11:0] PLB_ADDR_PTERM = 12'h400;

    // polarity register fields
    localparam int PLB_POL_OE_LSB = 0;
    localparam int PLB_POL_SET_BIT = 4;
    localparam int PLB_POL_RST_BIT = 5;
    localparam int PLB_POL_CLK_BIT = 6;
    localparam logic [6:0] PLB_POL_RESET = 7'h00;

    // macrocell configuration fields
    localparam int PLB_MC_REG_BIT = 0;
    localparam int PLB_MC_OESEL_BIT = 1;
    localparam int PLB_MC_INV_BIT = 2;
    localparam int PLB_MC_PTCLK_BIT = 3;
    localparam logic [3:0] PLB_MCCFG_RESET = 4'h0;

    // product term word 2 fields
    localparam int PLB_PT_ALLOC_BIT = 8;
    localparam int PLB_PT_OWNER_LSB = 12;
    localparam logic [PLB_N_LIT-1:0] PLB_MASK_RESET = 72'h0;

endpackage : plb_pkg

//--- logic/plb_pterm.sv
// one programmable product term: its literal mask, allocation and owner.
// assumes the 72-literal field is driven combinationally by the block.
`timescale 1ns/100ps
module plb_pterm import plb_pkg::*; (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [1:0] wr_word,
    input wire logic [31:0] wdata,
    input wire logic [1:0] rd_word,
    input wire logic [PLB_N_LIT-1:0] field,
    output logic prod,
    output logic alloc,
    output logic [3:0] owner,
    output logic [31:0] rd_data
);

    typedef struct packed {
        logic [PLB_N_LIT-1:0] mask;
        logic alloc;
        logic [3:0] owner;
    } plb_pterm_s;

    plb_pterm_s st;
    plb_pterm_s next_st;

    // configuration writes, one word at a time
    always_comb begin
        next_st = st;
        if (wr_en) begin
            unique case (wr_word)
                2'h0: next_st.mask[31:0] = wdata;
                2'h1: next_st.mask[63:32] = wdata;
                2'h2: begin
                    next_st.mask[71:64] = wdata[7:0];
                    next_st.alloc = wdata[PLB_PT_ALLOC_BIT];
                    next_st.owner = wdata[PLB_PT_OWNER_LSB +: 4];
                end
                default: next_st = st;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{mask: PLB_MASK_RESET, alloc: 1'b0, owner: 4'h0};
        end else begin
            st <= next_st;
        end
    end

    // and of every chosen literal; an empty mask gives a dead term
    assign prod = (|st.mask) && ((st.mask & ~field) == '0);
    assign alloc = st.alloc;
    assign owner = st.owner;

    // readback of the addressed word
    always_comb begin
        unique case (rd_word)
            2'h0: rd_data = st.mask[31:0];
            2'h1: rd_data = st.mask[63:32];
            2'h2: rd_data = {16'h0, st.owner, 3'h0, st.alloc, st.mask[71:64]};
            default: rd_data = 32'h0;
        endcase
    end

    a_pterm_and: assert property (@(posedge core_clk) disable iff (!rst_n)
        prod |-> ((st.mask & ~field) == '0) && (st.mask != '0))
        else $error("product term true while a chosen literal is false");

endmodule : plb_pterm

//--- logic/plb_macrocell.sv
// one macrocell: polarity, register or pass-through, set and reset override.
// assumes set, reset and clock-edge terms arrive already polarity-adjusted.
`timescale 1ns/100ps
module plb_macrocell import plb_pkg::*; (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic sum,
    input wire logic [3:0] cfg,
    input wire logic set_act,
    input wire logic rst_act,
    input wire logic clk_rise,
    output logic mc_out
);

    typedef struct packed {
        logic q;
    } plb_mc_s;

    plb_mc_s st;
    plb_mc_s next_st;
    logic d;
    logic load;

    assign d = sum ^ cfg[PLB_MC_INV_BIT];
    assign load = cfg[PLB_MC_PTCLK_BIT] ? clk_rise : 1'b1;

    // reset term beats set term, both beat the clock
    always_comb begin
        next_st = st;
        if (rst_act) begin
            next_st.q = 1'b0;
        end else if (set_act) begin
            next_st.q = 1'b1;
        end else if (load) begin
            next_st.q = d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{q: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // overrides show at once, without waiting for a clock
    always_comb begin
        if (!cfg[PLB_MC_REG_BIT]) begin
            mc_out = d;
        end else if (rst_act) begin
            mc_out = 1'b0;
        end else if (set_act) begin
            mc_out = 1'b1;
        end else begin
            mc_out = st.q;
        end
    end

    a_mc_force: assert property (@(posedge core_clk) disable iff (!rst_n)
        cfg[PLB_MC_REG_BIT] && (set_act || rst_act) |-> mc_out == !rst_act)
        else $error("set or reset term did not force the macrocell at once");

    a_mc_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        cfg[PLB_MC_PTCLK_BIT] && !clk_rise && !set_act && !rst_act |=> $stable(st.q))
        else $error("macrocell register moved without a clock term edge");

endmodule : plb_macrocell

//--- logic/plb_logic_block.sv
// logic block with its global routing matrix, product term array and
// macrocells, configured over apb.
// assumes all pins and feedbacks are synchronous to core_clk; pready is
// always high, so every apb access completes in its first access cycle.
//
// Behaviour
// - any pin, dedicated input or macrocell feedback may feed any block input
// - 36 routed inputs, each given true and inverted, form 72 literals
// - 87 product terms, each able to use any of the 72 literals
// - 80 general terms are allocatable among the 16 macrocells
// - four enable terms; each io cell picks one of its pair
// - first enable pair serves upper half, second pair lower half
// - one term asynchronously sets, one resets the macrocell registers
// - one further term acts as clock for the macrocell registers
// - set, reset, enable and clock terms each have polarity control
// - routing delay is the same whichever source is chosen
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
module plb_logic_block import plb_pkg::*; #(
    parameter int N_PIN = 64,
    parameter int N_DED = 4,
    parameter int N_FB_EXT = 112
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [N_PIN-1:0] pin_in,
    input wire logic [N_DED-1:0] ded_in,
    input wire logic [N_FB_EXT-1:0] fb_ext,
    output logic [PLB_N_MC-1:0] io_out,
    output logic [PLB_N_MC-1:0] io_oe,
    output logic [PLB_N_MC-1:0] fb_out
);

    localparam int N_SRC = N_PIN + N_DED + N_FB_EXT + PLB_N_MC;

    typedef struct packed {
        logic [PLB_N_IN-1:0][PLB_SEL_W-1:0] route;
        logic [PLB_N_MC-1:0][3:0] mccfg;
        logic [6:0] pol;
        logic [PLB_N_MC-1:0] io_out;
        logic [PLB_N_MC-1:0] io_oe;
        logic ptclk_d;
        logic [31:0] prdata;
        logic pslverr;
    } plb_block_s;

    plb_block_s st;
    plb_block_s next_st;

    logic [N_SRC-1:0] src;
    logic [PLB_N_IN-1:0] in_true;
    logic [PLB_N_LIT-1:0] field;
    logic [PLB_N_PT-1:0] pt;
    logic [PLB_N_PT-1:0] pt_alloc;
    logic [PLB_N_PT-1:0][3:0] pt_owner;
    logic [PLB_N_PT-1:0][31:0] pt_rd;
    logic [PLB_N_PT-1:0] pt_wr;
    logic [PLB_N_MC-1:0] mc_sum;
    logic [PLB_N_MC-1:0] mc_out;
    logic [PLB_N_OE-1:0] oe_act;
    logic set_act;
    logic rst_act;
    logic clk_act;
    logic clk_rise;
    logic setup;
    logic access;
    logic hit_route;
    logic hit_mccfg;
    logic hit_pterm;
    logic hit_reg;
    logic [11:0] pt_off;
    logic [6:0] pt_idx;
    logic [5:0] route_idx;
    logic [3:0] mc_idx;

    // every source the matrix can reach, own feedbacks included
    assign src = {mc_out, fb_ext, ded_in, pin_in};

    // one flat mux level per input, so no route is slower than another
    always_comb begin
        for (int i = 0; i < PLB_N_IN; i++) begin
            if (int'(st.route[i]) < N_SRC) begin
                in_true[i] = src[st.route[i]];
            end else begin
                in_true[i] = 1'b0;
            end
        end
    end

    // literal 2i is the true copy, 2i+1 the inverted copy
    always_comb begin
        for (int i = 0; i < PLB_N_IN; i++) begin
            field[2*i] = in_true[i];
            field[2*i+1] = ~in_true[i];
        end
    end

    // the product term array
    genvar g;
    generate
        for (g = 0; g < PLB_N_PT; g++) begin : g_pt
            plb_pterm u_pt (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .wr_en(pt_wr[g]),
                .wr_word(paddr[3:2]),
                .wdata(pwdata),
                .rd_word(paddr[3:2]),
                .field(field),
                .prod(pt[g]),
                .alloc(pt_alloc[g]),
                .owner(pt_owner[g]),
                .rd_data(pt_rd[g])
            );
        end
    endgenerate

    // general terms summed into the macrocell that owns them
    always_comb begin
        mc_sum = '0;
        for (int t = 0; t < PLB_N_GEN; t++) begin
            if (pt[t] && pt_alloc[t]) begin
                mc_sum[pt_owner[t]] = 1'b1;
            end
        end
    end

    // special terms, each with its own polarity bit
    assign oe_act = pt[PLB_PT_OE0 +: PLB_N_OE] ^ st.pol[PLB_POL_OE_LSB +: PLB_N_OE];
    assign set_act = pt[PLB_PT_SET] ^ st.pol[PLB_POL_SET_BIT];
    assign rst_act = pt[PLB_PT_RST] ^ st.pol[PLB_POL_RST_BIT];
    assign clk_act = pt[PLB_PT_CLK] ^ st.pol[PLB_POL_CLK_BIT];
    assign clk_rise = clk_act && !st.ptclk_d;

    // the sixteen macrocells
    generate
        for (g = 0; g < PLB_N_MC; g++) begin : g_mc
            plb_macrocell u_mc (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .sum(mc_sum[g]),
                .cfg(st.mccfg[g]),
                .set_act(set_act),
                .rst_act(rst_act),
                .clk_rise(clk_rise),
                .mc_out(mc_out[g])
            );
        end
    endgenerate

    // apb decode
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign pt_off = paddr - PLB_ADDR_PTERM;
    assign pt_idx = pt_off[10:4];
    assign route_idx = paddr[7:2];
    assign mc_idx = paddr[5:2];
    assign hit_reg = (paddr == PLB_ADDR_POL) || (paddr == PLB_ADDR_MCOUT)
        || (paddr == PLB_ADDR_IOOE);
    assign hit_route = (paddr[11:8] == PLB_ADDR_ROUTE[11:8]) && (paddr[1:0] == 2'h0)
        && (int'(route_idx) < PLB_N_IN);
    assign hit_mccfg = (paddr[11:8] == PLB_ADDR_MCCFG[11:8]) && (paddr[7:6] == 2'h0)
        && (paddr[1:0] == 2'h0);
    assign hit_pterm = (paddr >= PLB_ADDR_PTERM) && (int'(pt_idx) < PLB_N_PT)
        && (paddr[3:2] != 2'h3) && (paddr[1:0] == 2'h0) && (pt_off[11] == 1'b0);

    // write strobes to the product terms
    always_comb begin
        pt_wr = '0;
        if (access && pwrite && hit_pterm) begin
            pt_wr[pt_idx] = 1'b1;
        end
    end

    // register file, pin drivers and read data
    always_comb begin
        next_st = st;
        next_st.ptclk_d = clk_act;
        next_st.io_out = mc_out;
        for (int m = 0; m < PLB_N_MC; m++) begin
            if (m < PLB_HALF) begin
                next_st.io_oe[m] = oe_act[{1'b0, st.mccfg[m][PLB_MC_OESEL_BIT]}];
            end else begin
                next_st.io_oe[m] = oe_act[{1'b1, st.mccfg[m][PLB_MC_OESEL_BIT]}];
            end
        end
        if (access && pwrite) begin
            if (paddr == PLB_ADDR_POL) begin
                next_st.pol = pwdata[6:0];
            end else if (hit_route) begin
                next_st.route[route_idx] = pwdata[PLB_SEL_W-1:0];
            end else if (hit_mccfg) begin
                next_st.mccfg[mc_idx] = pwdata[3:0];
            end
        end
        if (setup) begin
            next_st.prdata = 32'h0;
            next_st.pslverr = !(hit_reg || hit_route || hit_mccfg || hit_pterm);
            if (paddr == PLB_ADDR_POL) begin
                next_st.prdata = {25'h0, st.pol};
            end else if (paddr == PLB_ADDR_MCOUT) begin
                next_st.prdata = {16'h0, mc_out};
            end else if (paddr == PLB_ADDR_IOOE) begin
                next_st.prdata = {16'h0, st.io_oe};
            end else if (hit_route) begin
                next_st.prdata = {24'h0, st.route[route_idx]};
            end else if (hit_mccfg) begin
                next_st.prdata = {28'h0, st.mccfg[mc_idx]};
            end else if (hit_pterm) begin
                next_st.prdata = pt_rd[pt_idx];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < PLB_N_IN; i++) begin
                st.route[i] <= PLB_SEL_W'(i);
            end
            st.mccfg <= {PLB_N_MC{PLB_MCCFG_RESET}};
            st.pol <= PLB_POL_RESET;
            st.io_out <= '0;
            st.io_oe <= '0;
            st.ptclk_d <= 1'b0;
            st.prdata <= 32'h0;
            st.pslverr <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // outputs
    assign prdata = st.prdata;
    assign pready = 1'b1;
    assign pslverr = st.pslverr && access;
    assign io_out = st.io_out;
    assign io_oe = st.io_oe;
    assign fb_out = mc_out;

    // checks
    a_route_source: assert property (@(posedge core_clk) disable iff (!rst_n)
        (int'(st.route[0]) < N_SRC) |-> in_true[0] == src[st.route[0]])
        else $error("routed input 0 does not follow its chosen source");

    // a selector beyond the last source must give a quiet input
    a_route_refuse: assert property (@(posedge core_clk) disable iff (!rst_n)
        (int'(st.route[0]) >= N_SRC) |-> !in_true[0])
        else $error("routed input 0 not low for an out-of-range selector");

    a_route_flat: assert property (@(posedge core_clk) disable iff (!rst_n)
        (int'(st.route[35]) < N_SRC) |-> field[70] == src[st.route[35]])
        else $error("routed input 35 lags or misses its source");

    // every even literal and its odd neighbour must differ
    a_lit_pairs: assert property (@(posedge core_clk) disable iff (!rst_n)
        ((field ^ (field >> 1)) & {PLB_N_IN{2'b01}}) == {PLB_N_IN{2'b01}})
        else $error("literal pair not true and inverted");

    a_gen_alloc: assert property (@(posedge core_clk) disable iff (!rst_n)
        pt[0] && pt_alloc[0] |-> mc_sum[pt_owner[0]])
        else $error("allocated general term missing from its macrocell");

    a_oe_upper: assert property (@(posedge core_clk) disable iff (!rst_n)
        1'b1 |=> io_oe[0] == $past(oe_act[st.mccfg[0][PLB_MC_OESEL_BIT]]))
        else $error("upper io cell enable not from first pair");

    // the two cells either side of the half boundary
    a_oe_half: assert property (@(posedge core_clk) disable iff (!rst_n)
        1'b1 |=> (io_oe[7] == $past(oe_act[st.mccfg[7][PLB_MC_OESEL_BIT]]))
        && (io_oe[8] == $past(oe_act[2 + st.mccfg[8][PLB_MC_OESEL_BIT]])))
        else $error("enable pair crosses the half boundary");

    a_oe_lower: assert property (@(posedge core_clk) disable iff (!rst_n)
        1'b1 |=> io_oe[15] == $past(oe_act[2 + st.mccfg[15][PLB_MC_OESEL_BIT]]))
        else $error("lower io cell enable not from second pair");

    a_io_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
        1'b1 |=> io_out == $past(mc_out))
        else $error("pin outputs do not follow the macrocells by one cycle");

    a_pol_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        set_act != (pt[PLB_PT_SET] == st.pol[PLB_POL_SET_BIT]))
        else $error("set term polarity not applied");

    a_clk_edge: assert property (@(posedge core_clk) disable iff (!rst_n)
        !clk_act ##1 clk_act |-> clk_rise)
        else $error("clock term rising edge not seen");

    a_clk_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_rise |-> !$past(clk_act))
        else $error("clock term edge seen while the term was already high");

    a_set_reg: assert property (@(posedge core_clk) disable iff (!rst_n)
        set_act && !rst_act && st.mccfg[0][PLB_MC_REG_BIT] |-> mc_out[0])
        else $error("set term did not force macrocell 0");

    a_rst_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
        rst_act && st.mccfg[0][PLB_MC_REG_BIT] |-> !mc_out[0])
        else $error("reset term did not force macrocell 0 low");

endmodule : plb_logic_block

//--- verification/plb_pin_model.sv
// far-side model: device pins, dedicated inputs and other blocks' feedbacks
// assumes the bench hands it each new source pattern with a one-cycle load strobe
`timescale 1ns/100ps
module plb_pin_model #(
    parameter int W = 180
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    output logic [W-1:0] src
);
    // sources only change just after a rising edge, as synchronous pins do
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            src <= '0;
        end else if (load) begin
            src <= load_val;
        end
    end
endmodule : plb_pin_model

//--- verification/plb_logic_block_test.sv
// self-checking bench for the logic block: apb set-up, routing, terms, macrocells
// assumes zero-wait apb slave and the far-side pin model beside the block
`timescale 1ns/100ps
module plb_logic_block_test import plb_pkg::*;;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic load = 1'b0;
    logic [179:0] load_val = '0;
    logic [179:0] ext_src;
    logic [15:0] io_out;
    logic [15:0] io_oe;
    logic [15:0] fb_out;
    logic [179:0] srcv = '0;
    logic [191:0] rv;
    logic [31:0] rd;
    logic er;
    logic exp_b;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    int s;
    logic [15:0] oe_exp [4] = '{16'h00F7, 16'h0008, 16'hEF00, 16'h1000};

    plb_logic_block #(.N_PIN(64), .N_DED(4), .N_FB_EXT(112)) DUT (
        .core_clk(core_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(ext_src[63:0]),
        .ded_in(ext_src[67:64]), .fb_ext(ext_src[179:68]), .io_out(io_out),
        .io_oe(io_oe), .fb_out(fb_out)
    );
    plb_pin_model #(.W(180)) far_side (
        .core_clk(core_clk), .rst_n(rst_n), .load(load), .load_val(load_val),
        .src(ext_src)
    );

    // free-running clock and hang guard
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            final_report();
        end
    end

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_reg

    task automatic chk_pin(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_pin

    // one apb transfer: setup, then access held until pready is sampled high
    task automatic apb(input logic wr, input int a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= 12'(a);
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb

    task automatic wr(input int a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdchk(input string nm, input int a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk_reg(nm, e, rd);
    endtask : rdchk

    function automatic int pt(input int t, input int w);
        return 32'h400 + 16 * t + 4 * w;
    endfunction : pt

    task automatic term(input int t, input logic [71:0] m, input logic [31:0] top);
        wr(pt(t, 0), m[31:0]);
        wr(pt(t, 1), m[63:32]);
        wr(pt(t, 2), top | {24'h0, m[71:64]});
    endtask : term

    // new pattern on the far side, settled just after the loading edge
    task automatic drive(input logic [179:0] v);
        @(posedge core_clk);
        load <= 1'b1;
        load_val <= v;
        @(posedge core_clk);
        load <= 1'b0;
        #1;
        srcv = v;
    endtask : drive

    initial begin
        void'($urandom(32'h8407));
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        // reset values and an unmapped access
        rdchk("pol", PLB_ADDR_POL, 32'h0);
        rdchk("route5", PLB_ADDR_ROUTE + 20, 32'h5);
        rdchk("mccfg3", PLB_ADDR_MCCFG + 12, 32'h0);
        rdchk("iooe", PLB_ADDR_IOOE, 32'h0);
        chk_reg("mapped_err", 32'h0, {31'h0, er});
        chk_reg("pready", 32'h1, {31'h0, pready});
        apb(1'b0, 32'h00C, 32'h0);
        chk_reg("unmapped_rd", 32'h0, rd);
        chk_reg("unmapped_err", 32'h1, {31'h0, er});
        // any far-side source, then an out-of-range selector, through selector 0, true and inverted literal
        term(0, 72'h1, 32'h100);
        for (int i = 0; i < 14; i++) begin
            s = (i == 13) ? 200 : $urandom_range(179, 0);
            wr(PLB_ADDR_ROUTE, s);
            wr(pt(0, 0), (i % 2 == 1) ? 32'h2 : 32'h1);
            rv = {$urandom(), $urandom(), $urandom(), $urandom(), $urandom(), $urandom()};
            drive(rv[179:0]);
            exp_b = ((s < 180) ? srcv[s] : 1'b0) ^ (i % 2 == 1);
            chk_pin("fb_out", {15'h0, exp_b}, fb_out);
            @(posedge core_clk);
            #1;
            chk_pin("io_out", {15'h0, exp_b}, io_out);
        end
        // term now constant true: move it to macrocell 5, then withdraw it
        wr(pt(0, 2), 32'h5100);
        chk_pin("owner5", 16'h0020, fb_out);
        wr(pt(0, 2), 32'h5000);
        chk_pin("unalloc", 16'h0000, fb_out);
        wr(pt(0, 2), 32'h100);
        wr(PLB_ADDR_ROUTE, 0);
        wr(pt(0, 0), 32'h1);
        // enable terms: cells 3 and 12 pick the second of their pair
        wr(PLB_ADDR_MCCFG + 12, 32'h2);
        wr(PLB_ADDR_MCCFG + 48, 32'h2);
        for (int k = 0; k < 4; k++) begin
            wr(PLB_ADDR_POL, 32'h1 << k);
            @(posedge core_clk);
            #1;
            chk_pin("io_oe", oe_exp[k], io_oe);
            rdchk("iooe", PLB_ADDR_IOOE, {16'h0, oe_exp[k]});
        end
        // set and reset terms on a registered macrocell
        wr(PLB_ADDR_POL, 32'h0);
        wr(PLB_ADDR_MCCFG, 32'h1);
        drive('0);
        @(posedge core_clk);
        #1;
        chk_pin("reg_low", 16'h0, fb_out);
        wr(PLB_ADDR_POL, 32'h10);
        chk_pin("set", 16'h1, fb_out);
        rdchk("mcout", PLB_ADDR_MCOUT, 32'h1);
        wr(PLB_ADDR_POL, 32'h30);
        chk_pin("rst_wins", 16'h0, fb_out);
        wr(PLB_ADDR_POL, 32'h0);
        drive(180'h1);
        @(posedge core_clk);
        #1;
        chk_pin("reg_high", 16'h1, fb_out);
        // clock term from input 1, plain then inverted
        drive('0);
        @(posedge core_clk);
        wr(PLB_ADDR_ROUTE + 4, 1);
        term(86, 72'h4, 32'h0);
        wr(PLB_ADDR_MCCFG, 32'h9);
        drive(180'h1);
        repeat (3) @(posedge core_clk);
        #1;
        chk_pin("no_clk", 16'h0, fb_out);
        drive(180'h3);
        repeat (3) @(posedge core_clk);
        #1;
        chk_pin("pt_clk", 16'h1, fb_out);
        wr(PLB_ADDR_POL, 32'h40);
        drive(180'h2);
        repeat (3) @(posedge core_clk);
        #1;
        chk_pin("inv_hold", 16'h1, fb_out);
        drive('0);
        repeat (3) @(posedge core_clk);
        #1;
        chk_pin("inv_clk", 16'h0, fb_out);
        final_report();
    end
endmodule : plb_logic_block_test
